// >>> bscm_regs.svh
// constants for the buck start-up and conduction-mode controller:
// register offsets, field positions, reset values and timing figures.
// assumes inclusion by bare name from the modules, the checker and the bench.
`ifndef BSCM_REGS_SVH
`define BSCM_REGS_SVH

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define BSCM_OFS_CTRL      4'h0
`define BSCM_OFS_STATUS    4'h4
`define BSCM_OFS_IRQ_STAT  4'h8
`define BSCM_OFS_IRQ_MASK  4'hc

// ************************************************************
// control fields
// ************************************************************
`define BSCM_CTRL_ON_BIT   0
`define BSCM_CTRL_FDE_BIT  1
`define BSCM_CTRL_AF_BIT   2
`define BSCM_CTRL_RESET    32'h0000_0000

// ************************************************************
// interrupt event positions
// ************************************************************
`define BSCM_IRQ_POWER_GOOD_OUT_BIT 0
`define BSCM_IRQ_DEM_IN    1
`define BSCM_IRQ_DEM_OUT   2
`define BSCM_IRQ_PGLOST    3
`define BSCM_IRQ_W         4

// ************************************************************
// timing
// ************************************************************
`define BSCM_CLK_MHZ       100
`define BSCM_START_DLY_US  100
`define BSCM_START_DLY_CYC (`BSCM_START_DLY_US * `BSCM_CLK_MHZ)
`define BSCM_PG_CYCLES     6
`define BSCM_DEM_PULSES    8

// ************************************************************
// set-point in microvolts: 1287500 at code 0, steps of 25750, 412000 at code 31
// ************************************************************
`define BSCM_VID_TOP_UV    1287500
`define BSCM_VID_STEP_UV   25750
`define BSCM_VID_LAST_UV   412000
`define BSCM_FW_BASE       8'h64
`define BSCM_FW_DEM        8'h85

`endif

// >>> bscm_pkg.sv
// types shared by the controller modules.
// assumes bscm_regs.svh is on the include path.
`default_nettype none
package bscm_pkg;
    typedef enum logic [2:0]
    {
        BSCM_OFF     = 3'b000,
        BSCM_DELAY   = 3'b001,
        BSCM_SOFT    = 3'b010,
        BSCM_COUNT   = 3'b011,
        BSCM_RUN     = 3'b100
    } bscm_seq_t;
endpackage : bscm_pkg
`default_nettype wire

// >>> bscm_vid_dec.sv
// voltage-identification decoder: code to set-point in microvolts.
// assumes a stable 5-bit code; purely combinational.
`include "bscm_regs.svh"
`default_nettype none
module bscm_vid_dec
    import bscm_pkg::*;
(
    input  wire logic [4:0]  voltage_id_code,
    output logic      [20:0] setpoint_uv,
    output logic             suspend_code
);
    logic [20:0] step_sum;

    always_comb
    begin
        // bit 0 is the lsb, bit 4 the msb of the code
        step_sum = 21'(voltage_id_code) * 21'(`BSCM_VID_STEP_UV);
        if (voltage_id_code == 5'h1f)
        begin
            setpoint_uv = 21'(`BSCM_VID_LAST_UV);
        end
        else
        begin
            setpoint_uv = 21'(`BSCM_VID_TOP_UV) - step_sum;
        end
        suspend_code = voltage_id_code[4];
    end
endmodule : bscm_vid_dec
`default_nettype wire

// >>> bscm_dem_det.sv
// diode-emulation detector: counts positive switch-node readings
// taken once per low-side turn-on; clears on any negative reading.
// assumes phase_positive is valid in the cycle of low_side_gate_rise.
`include "bscm_regs.svh"
`default_nettype none
module bscm_dem_det
    import bscm_pkg::*;
#(
    parameter int PULSES = `BSCM_DEM_PULSES
)
(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic permit,
    input  wire logic low_side_gate_rise,
    input  wire logic phase_positive,
    output logic      dem_r
);
    localparam int CW = $clog2(PULSES + 1);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          dem_nxt;

    initial
    begin
        if (PULSES < 1)
        begin
            $error("PULSES must be at least one");
        end
    end

    always_comb
    begin
        cnt_nxt = cnt_r;
        dem_nxt = dem_r;
        if (!permit)
        begin
            cnt_nxt = '0;
            dem_nxt = 1'b0;
        end
        else if (low_side_gate_rise)
        begin
            if (!phase_positive)
            begin
                // back to synchronous rectification next cycle
                cnt_nxt = '0;
                dem_nxt = 1'b0;
            end
            else if (cnt_r != CW'(PULSES))
            begin
                cnt_nxt = cnt_r + CW'(1);
                dem_nxt = (cnt_r == CW'(PULSES - 1));
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cnt_r <= '0;
            dem_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            dem_r <= dem_nxt;
        end
    end
endmodule : bscm_dem_det
`default_nettype wire

// >>> bscm_ctrl.sv
// start-up sequencer and conduction-mode selection of a buck controller,
// with an avalon-mm register slave and one level interrupt.
// assumes rst follows the supply power-on-reset comparator, and that
// switching events arrive as one-cycle pulses synchronous to core_clk.
`include "bscm_regs.svh"
`default_nettype none
module bscm_ctrl
    import bscm_pkg::*;
#(
    parameter int START_DLY_CYC = `BSCM_START_DLY_CYC,
    parameter int PG_CYCLES     = `BSCM_PG_CYCLES
)
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    // pins
    input  wire logic        regulator_on_request,
    input  wire logic        force_diode_emulation_sel,
    input  wire logic        audio_filter_sel,
    input  wire logic [4:0]  voltage_id_code,
    input  wire logic        soft_done,
    input  wire logic        output_within_10pct,
    input  wire logic        switch_cycle,
    input  wire logic        low_side_gate_rise,
    input  wire logic        phase_positive,
    output logic             converter_enable,
    output logic             soft_start_active,
    output logic      [20:0] setpoint_uv,
    output logic             diode_emulation_state,
    output logic             audio_filter_on,
    output logic      [7:0]  freq_window,
    output logic             power_good_out,
    output logic             power_good_oe_n
);
    localparam int DW = $clog2(START_DLY_CYC + 1);
    localparam int PW = $clog2(PG_CYCLES + 1);

    initial
    begin
        if (START_DLY_CYC < 1 || PG_CYCLES < 1)
        begin
            $error("delay and cycle counts must be at least one");
        end
    end

    // ************************************************************
    // register bus
    // ************************************************************
    logic [2:0]  ctrl_r;
    logic [2:0]  ctrl_nxt;
    logic [3:0]  irq_stat_r;
    logic [3:0]  irq_stat_nxt;
    logic [3:0]  irq_mask_r;
    logic [3:0]  irq_mask_nxt;
    logic        ack_r;
    logic        ack_nxt;
    logic [31:0] rdata_nxt;
    logic [31:0] status_word;
    logic [3:0]  events;
    logic        bus_req;

    // the request is answered one cycle after it appears, with waitrequest low in that cycle only
    assign bus_req = (avs_read || avs_write) && !ack_r;

    always_comb
    begin
        ctrl_nxt     = ctrl_r;
        irq_mask_nxt = irq_mask_r;
        ack_nxt      = bus_req;
        rdata_nxt    = avs_readdata;
        // set beats clear so no event is lost
        irq_stat_nxt = irq_stat_r;
        if (bus_req && avs_write && avs_byteenable[0])
        begin
            unique case (avs_address)
                `BSCM_OFS_CTRL:     ctrl_nxt = avs_writedata[2:0];
                `BSCM_OFS_IRQ_STAT: irq_stat_nxt = irq_stat_r & ~avs_writedata[3:0];
                `BSCM_OFS_IRQ_MASK: irq_mask_nxt = avs_writedata[3:0];
                default:            ctrl_nxt = ctrl_r;
            endcase
        end
        irq_stat_nxt = irq_stat_nxt | events;
        if (bus_req && avs_read)
        begin
            unique case (avs_address)
                `BSCM_OFS_CTRL:     rdata_nxt = {29'h0, ctrl_r};
                `BSCM_OFS_STATUS:   rdata_nxt = status_word;
                `BSCM_OFS_IRQ_STAT: rdata_nxt = {28'h0, irq_stat_r};
                `BSCM_OFS_IRQ_MASK: rdata_nxt = {28'h0, irq_mask_r};
                default:            rdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ctrl_r       <= 3'h0;
            irq_stat_r   <= 4'h0;
            irq_mask_r   <= 4'h0;
            ack_r        <= 1'b0;
            avs_readdata <= 32'h0;
            irq          <= 1'b0;
        end
        else
        begin
            ctrl_r       <= ctrl_nxt;
            irq_stat_r   <= irq_stat_nxt;
            irq_mask_r   <= irq_mask_nxt;
            ack_r        <= ack_nxt;
            avs_readdata <= rdata_nxt;
            irq          <= |(irq_stat_nxt & irq_mask_nxt);
        end
    end

    // waitrequest is high except in the answer cycle
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            avs_waitrequest <= !ack_nxt;
        end
    end

    // ************************************************************
    // start-up sequencer
    // ************************************************************
    bscm_seq_t   st_r;
    bscm_seq_t   st_nxt;
    logic [DW-1:0] dly_r;
    logic [DW-1:0] dly_nxt;
    logic [PW-1:0] pg_r;
    logic [PW-1:0] pg_nxt;
    logic        on_req;
    logic        pg_nxt_out;

    // the pin and the software bit both request the converter on
    assign on_req = regulator_on_request || ctrl_r[`BSCM_CTRL_ON_BIT];

    always_comb
    begin
        st_nxt  = st_r;
        dly_nxt = dly_r;
        pg_nxt  = pg_r;
        if (!on_req)
        begin
            st_nxt  = BSCM_OFF;
            dly_nxt = '0;
            pg_nxt  = '0;
        end
        else
        begin
            unique case (st_r)
                BSCM_OFF:
                begin
                    st_nxt  = BSCM_DELAY;
                    dly_nxt = '0;
                end
                BSCM_DELAY:
                begin
                    dly_nxt = dly_r + DW'(1);
                    if (dly_r == DW'(START_DLY_CYC - 1))
                    begin
                        st_nxt = BSCM_SOFT;
                    end
                end
                BSCM_SOFT:
                begin
                    if (soft_done && output_within_10pct)
                    begin
                        st_nxt = BSCM_COUNT;
                        pg_nxt = '0;
                    end
                end
                BSCM_COUNT:
                begin
                    if (!output_within_10pct)
                    begin
                        pg_nxt = '0;
                    end
                    else if (switch_cycle)
                    begin
                        pg_nxt = pg_r + PW'(1);
                        if (pg_r == PW'(PG_CYCLES - 1))
                        begin
                            st_nxt = BSCM_RUN;
                        end
                    end
                end
                BSCM_RUN:
                begin
                    st_nxt = BSCM_RUN;
                end
                default:
                begin
                    st_nxt = BSCM_OFF;
                end
            endcase
        end
    end

    // power good only in run; released pin means oe_n high
    assign pg_nxt_out = (st_nxt == BSCM_RUN);

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st_r              <= BSCM_OFF;
            dly_r             <= '0;
            pg_r              <= '0;
            converter_enable  <= 1'b0;
            soft_start_active <= 1'b0;
            power_good_out    <= 1'b0;
            power_good_oe_n   <= 1'b0;
        end
        else
        begin
            st_r              <= st_nxt;
            dly_r             <= dly_nxt;
            pg_r              <= pg_nxt;
            converter_enable  <= (st_nxt != BSCM_OFF) && (st_nxt != BSCM_DELAY);
            soft_start_active <= (st_nxt == BSCM_SOFT);
            power_good_out    <= 1'b0;
            power_good_oe_n   <= pg_nxt_out;
        end
    end

    // ************************************************************
    // set-point and conduction mode
    // ************************************************************
    logic [20:0] sp_dec;
    logic        suspend_code;
    logic        dem_permit;
    logic        dem_now;
    logic        dem_prev_r;
    logic        fde_sel;
    logic        af_sel;
    logic        af_on;
    logic        dem_out;

    bscm_vid_dec u_vid
    (
        .voltage_id_code (voltage_id_code),
        .setpoint_uv     (sp_dec),
        .suspend_code    (suspend_code)
    );

    assign fde_sel = force_diode_emulation_sel || ctrl_r[`BSCM_CTRL_FDE_BIT];
    assign af_sel  = audio_filter_sel || ctrl_r[`BSCM_CTRL_AF_BIT];
    // filter acts only in suspend codes with force-emulation select low
    assign af_on   = af_sel && suspend_code && !fde_sel;

    // no emulation outside regulation, and never during soft-start
    assign dem_permit = (st_r == BSCM_COUNT || st_r == BSCM_RUN)
                        && (fde_sel || suspend_code);

    bscm_dem_det u_dem
    (
        .core_clk       (core_clk),
        .rst            (rst),
        .permit         (dem_permit),
        .low_side_gate_rise     (low_side_gate_rise),
        .phase_positive (phase_positive),
        .dem_r          (dem_now)
    );

    assign events = {
        (st_r == BSCM_RUN) && (st_nxt != BSCM_RUN),
        dem_prev_r && !dem_now,
        !dem_prev_r && dem_now,
        (st_r != BSCM_RUN) && (st_nxt == BSCM_RUN)
    };

    assign status_word = {freq_window, st_r, sp_dec[19:0], dem_now};
    assign dem_out = dem_now && (st_nxt == BSCM_COUNT || st_nxt == BSCM_RUN);

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            setpoint_uv           <= 21'h0;
            diode_emulation_state <= 1'b0;
            audio_filter_on       <= 1'b0;
            freq_window           <= `BSCM_FW_BASE;
            dem_prev_r            <= 1'b0;
        end
        else
        begin
            setpoint_uv           <= sp_dec;
            diode_emulation_state <= dem_out;
            audio_filter_on       <= af_on;
            freq_window           <= (dem_out && !af_on) ? `BSCM_FW_DEM : `BSCM_FW_BASE;
            dem_prev_r            <= dem_now;
        end
    end
endmodule : bscm_ctrl
`default_nettype wire

// >>> bscm_ctrl_sva.sv
// concurrent checks on the ports of the start-up and conduction-mode controller.
// assumes it is bound to bscm_ctrl and that everything runs on core_clk.
`include "bscm_regs.svh"
`default_nettype none
module bscm_ctrl_sva
(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        irq,
    input wire logic        force_diode_emulation_sel,
    input wire logic [4:0]  voltage_id_code,
    input wire logic        output_within_10pct,
    input wire logic        low_side_gate_rise,
    input wire logic        phase_positive,
    input wire logic        converter_enable,
    input wire logic        soft_start_active,
    input wire logic [20:0] setpoint_uv,
    input wire logic        diode_emulation_state,
    input wire logic        audio_filter_on,
    input wire logic [7:0]  freq_window,
    input wire logic        power_good_out,
    input wire logic        power_good_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // properties
    // ************************************************************
    logic [20:0] sp_exp;
    // the last code breaks the linear step, so it is taken apart
    assign sp_exp = (voltage_id_code == 5'h1f) ? 21'(`BSCM_VID_LAST_UV) :
        21'(`BSCM_VID_TOP_UV - `BSCM_VID_STEP_UV * voltage_id_code);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_rst_off;
        $fell(rst) |-> !converter_enable && !power_good_oe_n && !diode_emulation_state && !irq;
    endproperty
    a_rst_off: assert property (p_rst_off) else $error("outputs not idle after reset");
    property p_pg_pin;
        power_good_out == 1'b0;
    endproperty
    a_pg_pin: assert property (p_pg_pin) else $error("open-drain pin driven high");
    property p_pg_en;
        power_good_oe_n |-> converter_enable && !soft_start_active;
    endproperty
    a_pg_en: assert property (p_pg_en) else $error("power good released outside run");
    property p_pg_rise;
        $rose(power_good_oe_n) |-> $past(output_within_10pct) && $past(converter_enable);
    endproperty
    a_pg_rise: assert property (p_pg_rise) else $error("power good released out of window");
    property p_soft;
        soft_start_active |-> !diode_emulation_state;
    endproperty
    a_soft: assert property (p_soft) else $error("emulation during soft-start");
    property p_dem_en;
        diode_emulation_state |-> converter_enable;
    endproperty
    a_dem_en: assert property (p_dem_en) else $error("emulation with converter off");
    property p_dem_rise;
        $rose(diode_emulation_state) |-> $past(low_side_gate_rise) || $past(low_side_gate_rise, 2);
    endproperty
    a_dem_rise: assert property (p_dem_rise) else $error("emulation entered without a pulse");
    property p_dem_permit;
        $rose(diode_emulation_state) |-> $past(force_diode_emulation_sel) || $past(voltage_id_code) >= 5'h10;
    endproperty
    a_dem_permit: assert property (p_dem_permit) else $error("emulation on a forbidden code");
    property p_exit;
        diode_emulation_state && low_side_gate_rise && !phase_positive |-> ##[1:2] !diode_emulation_state;
    endproperty
    a_exit: assert property (p_exit) else $error("emulation kept after negative reading");
    property p_win_dem;
        (diode_emulation_state && !audio_filter_on) [*2] |-> freq_window == `BSCM_FW_DEM;
    endproperty
    a_win_dem: assert property (p_win_dem) else $error("window not raised in emulation");
    property p_win_af;
        (diode_emulation_state && audio_filter_on) [*2] |-> freq_window == `BSCM_FW_BASE;
    endproperty
    a_win_af: assert property (p_win_af) else $error("window raised with filter on");
    property p_win_ccm;
        (!diode_emulation_state) [*2] |-> freq_window == `BSCM_FW_BASE;
    endproperty
    a_win_ccm: assert property (p_win_ccm) else $error("window raised outside emulation");
    property p_sp;
        $stable(voltage_id_code) [*3] |-> setpoint_uv == sp_exp;
    endproperty
    a_sp: assert property (p_sp) else $error("set-point does not match code");
    c_pg: cover property ($rose(power_good_oe_n));
    c_dem_in: cover property ($rose(diode_emulation_state));
    c_dem_out: cover property ($fell(diode_emulation_state));
    c_irq: cover property ($rose(irq));
endmodule : bscm_ctrl_sva
bind bscm_ctrl bscm_ctrl_sva i_sva
(
    .core_clk, .rst, .irq, .force_diode_emulation_sel, .voltage_id_code, .output_within_10pct,
    .low_side_gate_rise, .phase_positive, .converter_enable, .soft_start_active, .setpoint_uv,
    .diode_emulation_state, .audio_filter_on, .freq_window, .power_good_out, .power_good_oe_n
);
`default_nettype wire

// >>> bscm_stage_model.sv
// behavioural power stage: ramp, switching pulses and switch-node polarity.
// assumes converter_enable from the controller starts and stops it.
`default_nettype none
module bscm_stage_model
#(
    parameter int PER  = 4,
    parameter int RAMP = 10
)
(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic converter_enable,
    input  wire logic light_load,
    output logic      soft_done,
    output logic      output_within_10pct,
    output logic      switch_cycle,
    output logic      low_side_gate_rise,
    output logic      phase_positive
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // stage
    // ************************************************************
    int ph_r;
    int rc_r;
    always_ff @(posedge core_clk)
    begin
        if (rst || !converter_enable)
        begin
            ph_r <= 0;
            rc_r <= 0;
            soft_done <= 1'b0;
            output_within_10pct <= 1'b0;
            switch_cycle <= 1'b0;
            low_side_gate_rise <= 1'b0;
            // stage idle: the reading is meaningless, so it keeps moving
            phase_positive <= rst ? 1'b0 : ~phase_positive;
        end
        else
        begin
            ph_r <= (ph_r == PER - 1) ? 0 : ph_r + 1;
            switch_cycle <= (ph_r == 0);
            low_side_gate_rise <= (ph_r == 0);
            phase_positive <= (ph_r == 0) ? light_load : ~phase_positive;
            rc_r <= (rc_r == RAMP) ? rc_r : rc_r + 1;
            soft_done <= (rc_r == RAMP);
            output_within_10pct <= (rc_r == RAMP);
        end
    end
endmodule : bscm_stage_model
`default_nettype wire

// >>> tb_bscm_ctrl.sv
// self-checking bench for bscm_ctrl with the stage model on the far side.
// assumes bscm_pkg, bscm_regs.svh and the checker are compiled alongside.
`include "bscm_regs.svh"
`default_nettype none
module tb_bscm_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // bench
    // ************************************************************
    localparam int DLY = 20;
    localparam int PGC = 6;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq;
    logic        regulator_on_request = 1'b0;
    logic        force_diode_emulation_sel = 1'b0;
    logic        audio_filter_sel = 1'b0;
    logic [4:0]  voltage_id_code = 5'h00;
    logic        light_load = 1'b0;
    logic        soft_done, output_within_10pct, switch_cycle, low_side_gate_rise, phase_positive;
    logic        converter_enable, soft_start_active, diode_emulation_state, audio_filter_on;
    logic        power_good_out, power_good_oe_n;
    logic [20:0] setpoint_uv;
    logic [7:0]  freq_window;
    logic [31:0] rd;
    int          fails = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          pg_cnt = 0;
    always #5 core_clk = ~core_clk;
    bscm_ctrl #(.START_DLY_CYC(DLY), .PG_CYCLES(PGC)) i_dut
    (
        .core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
        .avs_readdata, .avs_waitrequest, .irq, .regulator_on_request, .force_diode_emulation_sel,
        .audio_filter_sel, .voltage_id_code, .soft_done, .output_within_10pct, .switch_cycle,
        .low_side_gate_rise, .phase_positive, .converter_enable, .soft_start_active, .setpoint_uv,
        .diode_emulation_state, .audio_filter_on, .freq_window, .power_good_out, .power_good_oe_n
    );
    bscm_stage_model i_stage
    (
        .core_clk, .rst, .converter_enable, .light_load, .soft_done, .output_within_10pct,
        .switch_cycle, .low_side_gate_rise, .phase_positive
    );
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr_en, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr_en;
        avs_read <= !wr_en;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge core_clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask : rd_chk
    // call just after a low-side pulse, or it takes the old polarity
    task automatic pulses(input int n, input logic pol);
        light_load <= pol;
        repeat (n) @(posedge core_clk iff low_side_gate_rise);
    endtask : pulses
    task automatic sync;
        @(posedge core_clk iff low_side_gate_rise);
    endtask : sync
    always @(posedge core_clk)
    begin
        cyc++;
        if (converter_enable && !soft_start_active && !power_good_oe_n && switch_cycle)
            pg_cnt++;
        if (cyc == 6000)
        begin
            fails++;
            test_done();
        end
    end
    initial
    begin
        int n;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk(32'(power_good_oe_n), 32'h0);
        rd_chk(`BSCM_OFS_CTRL, 32'hffff_ffff, `BSCM_CTRL_RESET);
        rd_chk(`BSCM_OFS_IRQ_STAT, 32'hffff_ffff, 32'h0);
        rd_chk(`BSCM_OFS_IRQ_MASK, 32'hffff_ffff, 32'h0);
        wr(4'h2, 32'hffff_ffff);
        rd_chk(4'h2, 32'hffff_ffff, 32'h0);
        for (int i = 0; i < 32; i++)
        begin
            voltage_id_code <= 5'(i);
            repeat (4) @(posedge core_clk);
            chk(32'(setpoint_uv), (i == 31) ? `BSCM_VID_LAST_UV : `BSCM_VID_TOP_UV - i * `BSCM_VID_STEP_UV);
        end
        voltage_id_code <= 5'h10;
        wr(`BSCM_OFS_IRQ_MASK, 32'hd);
        repeat (30) @(posedge core_clk);
        chk(32'(converter_enable), 32'h0);
        regulator_on_request <= 1'b1;
        n = 0;
        while (soft_start_active !== 1'b1)
        begin
            n++;
            @(posedge core_clk);
        end
        chk(32'(n >= DLY && n <= DLY + 3), 32'h1);
        while (power_good_oe_n !== 1'b1)
            @(posedge core_clk);
        chk(32'(pg_cnt), PGC);
        repeat (2) @(posedge core_clk);
        chk(32'(irq), 32'h1);
        rd_chk(`BSCM_OFS_IRQ_STAT, 32'h1, 32'h1);
        wr(`BSCM_OFS_IRQ_STAT, 32'h1);
        repeat (2) @(posedge core_clk);
        chk(32'(irq), 32'h0);
        sync();
        pulses(7, 1'b1);
        pulses(1, 1'b0);
        pulses(7, 1'b1);
        chk(32'(diode_emulation_state), 32'h0);
        pulses(1, 1'b1);
        repeat (3) @(posedge core_clk);
        chk(32'(diode_emulation_state), 32'h1);
        chk(32'(freq_window), `BSCM_FW_DEM);
        chk(32'(irq), 32'h0);
        wr(`BSCM_OFS_IRQ_MASK, 32'hf);
        repeat (2) @(posedge core_clk);
        chk(32'(irq), 32'h1);
        wr(`BSCM_OFS_IRQ_STAT, 32'h2);
        repeat (2) @(posedge core_clk);
        chk(32'(irq), 32'h0);
        audio_filter_sel <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk(32'(audio_filter_on), 32'h1);
        chk(32'(freq_window), `BSCM_FW_BASE);
        audio_filter_sel <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk(32'(audio_filter_on), 32'h0);
        chk(32'(freq_window), `BSCM_FW_DEM);
        sync();
        pulses(1, 1'b0);
        repeat (2) @(posedge core_clk);
        chk(32'(diode_emulation_state), 32'h0);
        rd_chk(`BSCM_OFS_IRQ_STAT, 32'h4, 32'h4);
        voltage_id_code <= 5'h05;
        sync();
        pulses(12, 1'b1);
        chk(32'(diode_emulation_state), 32'h0);
        pulses(1, 1'b0);
        force_diode_emulation_sel <= 1'b1;
        pulses(8, 1'b1);
        repeat (3) @(posedge core_clk);
        chk(32'(diode_emulation_state), 32'h1);
        regulator_on_request <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk(32'(converter_enable), 32'h0);
        chk(32'(power_good_oe_n), 32'h0);
        chk(32'(power_good_out), 32'h0);
        rd_chk(`BSCM_OFS_IRQ_STAT, 32'h8, 32'h8);
        regulator_on_request <= 1'b1;
        while (soft_start_active !== 1'b1)
            @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk(32'(converter_enable), 32'h0);
        rst <= 1'b0;
        test_done();
    end
endmodule : tb_bscm_ctrl
`default_nettype wire
